// file: verilog/pca_top.sv
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`include "pca_defs.svh"

module pca_top (
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [3:0] pwm_out
);

    // Configuration state
    logic [3:0] channel_enable_bit_q;
    logic [3:0] start_polarity_bit_q;
    logic [3:0] clock_select_q;
    logic [3:0] center_align_bit_q;
    logic [1:0] concat_q;
    pca_pkg::pca_pre_t prescale_field_a_q;
    pca_pkg::pca_pre_t prescale_field_b_q;
    pca_pkg::pca_byte_t scale_value_a_q;
    pca_pkg::pca_byte_t scale_value_b_q;
    pca_pkg::pca_byte_t period_q [4];
    pca_pkg::pca_byte_t duty_q [4];
    logic [3:0] channel_enable_bit_d;
    logic [3:0] start_polarity_bit_d;
    logic [3:0] clock_select_d;
    logic [3:0] center_align_bit_d;
    logic [1:0] concat_d;
    pca_pkg::pca_pre_t prescale_field_a_d;
    pca_pkg::pca_pre_t prescale_field_b_d;
    pca_pkg::pca_byte_t scale_value_a_d;
    pca_pkg::pca_byte_t scale_value_b_d;
    pca_pkg::pca_byte_t period_d [4];
    pca_pkg::pca_byte_t duty_d [4];

    // Bus state
    logic aw_full_q, aw_full_d, w_full_q, w_full_d;
    logic [7:0] waddr_q, waddr_d;
    pca_pkg::pca_byte_t wbyte_q, wbyte_d;
    logic wlane_q, wlane_d;
    logic awready_q, awready_d, wready_q, wready_d;
    logic bvalid_q, bvalid_d, arready_q, arready_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    logic wr_fire;
    logic [4:0] widx;
    logic [4:0] ridx;

    // Clock generation state
    logic [6:0] pre_cnt_q, pre_cnt_d;
    pca_pkg::pca_scnt_t scnt_a_q, scnt_a_d, scnt_b_q, scnt_b_d;
    logic tick_a, tick_b, tick_sa, tick_sb;
    logic [6:0] mask_a, mask_b;
    logic [9:0] load_a, load_b;
    logic [3:0] chan_tick;
    logic [3:0] chan_en;
    pca_pkg::pca_word_t chan_per [4];
    pca_pkg::pca_word_t chan_dty [4];
    pca_pkg::pca_word_t chan_cnt [4];

    function automatic logic mapped(input logic [7:0] a);
        logic [4:0] i;
        i = a[6:2];
        mapped = !a[7] && (i <= `PCA_IDX_CTL || i == `PCA_IDX_SCALE_A
            || i == `PCA_IDX_SCALE_B
            || (i >= `PCA_IDX_CNT0 && i <= `PCA_IDX_CNT3)
            || (i >= `PCA_IDX_PER0 && i <= `PCA_IDX_PER3)
            || (i >= `PCA_IDX_DTY0 && i <= `PCA_IDX_DTY3));
    endfunction

    assign widx = waddr_q[6:2];
    assign ridx = s_axi_araddr[6:2];
    assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

    // Bus handshakes; one write and one read in flight at most
    always_comb begin
        aw_full_d = aw_full_q;
        w_full_d = w_full_q;
        waddr_d = waddr_q;
        wbyte_d = wbyte_q;
        wlane_d = wlane_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        if (s_axi_awvalid && awready_q) begin
            aw_full_d = 1'b1;
            waddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_full_d = 1'b1;
            wbyte_d = s_axi_wdata[7:0];
            wlane_d = s_axi_wstrb[0];
        end
        if (wr_fire) begin
            aw_full_d = 1'b0;
            w_full_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = mapped(waddr_q) ? `PCA_RESP_OKAY : `PCA_RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d = mapped(s_axi_araddr) ? `PCA_RESP_OKAY
                                           : `PCA_RESP_SLVERR;
            rdata_d = '0;
            if (mapped(s_axi_araddr)) begin
                unique case (ridx)
                    `PCA_IDX_ENABLE: rdata_d[3:0] = channel_enable_bit_q;
                    `PCA_IDX_POLARITY: rdata_d[3:0] = start_polarity_bit_q;
                    `PCA_IDX_CLKSEL: rdata_d[3:0] = clock_select_q;
                    `PCA_IDX_PRESCALE: begin
                        rdata_d[`PCA_PRE_A_LSB +: 3] = prescale_field_a_q;
                        rdata_d[`PCA_PRE_B_LSB +: 3] = prescale_field_b_q;
                    end
                    `PCA_IDX_ALIGN: rdata_d[3:0] = center_align_bit_q;
                    `PCA_IDX_CTL: rdata_d[`PCA_CONCAT_PAIR_UPPER_BIT:`PCA_CONCAT_PAIR_LOWER_BIT] =
                        concat_q;
                    `PCA_IDX_SCALE_A: rdata_d[7:0] = scale_value_a_q;
                    `PCA_IDX_SCALE_B: rdata_d[7:0] = scale_value_b_q;
                    default: begin
                        // Counters, periods and duties by channel index
                        if (ridx >= `PCA_IDX_DTY0) begin
                            rdata_d[7:0] = duty_q[ridx[1:0]];
                        end else if (ridx >= `PCA_IDX_PER0) begin
                            rdata_d[7:0] = period_q[2'(ridx - `PCA_IDX_PER0)];
                        end else begin
                            rdata_d[7:0] = chan_cnt[ridx[1:0]][7:0];
                        end
                    end
                endcase
            end
        end else if (rvalid_q && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        awready_d = !aw_full_d && !bvalid_d;
        wready_d = !w_full_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            waddr_q <= '0;
            wbyte_q <= `PCA_RESET_BYTE;
            wlane_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= `PCA_RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rresp_q <= `PCA_RESP_OKAY;
            rdata_q <= '0;
        end else begin
            aw_full_q <= aw_full_d;
            w_full_q <= w_full_d;
            waddr_q <= waddr_d;
            wbyte_q <= wbyte_d;
            wlane_q <= wlane_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
        end
    end

    // Register writes land the cycle after both channels are held
    always_comb begin
        channel_enable_bit_d = channel_enable_bit_q;
        start_polarity_bit_d = start_polarity_bit_q;
        clock_select_d = clock_select_q;
        center_align_bit_d = center_align_bit_q;
        concat_d = concat_q;
        prescale_field_a_d = prescale_field_a_q;
        prescale_field_b_d = prescale_field_b_q;
        scale_value_a_d = scale_value_a_q;
        scale_value_b_d = scale_value_b_q;
        period_d = period_q;
        duty_d = duty_q;
        if (wr_fire && wlane_q && mapped(waddr_q)) begin
            unique case (widx)
                `PCA_IDX_ENABLE: channel_enable_bit_d = wbyte_q[3:0];
                `PCA_IDX_POLARITY:
                    start_polarity_bit_d = wbyte_q[3:0];
                `PCA_IDX_CLKSEL:
                    clock_select_d = wbyte_q[3:0];
                `PCA_IDX_PRESCALE: begin
                    prescale_field_a_d = wbyte_q[`PCA_PRE_A_LSB +: 3];
                    prescale_field_b_d = wbyte_q[`PCA_PRE_B_LSB +: 3];
                end
                // Hardware does not guard a change on a running channel
                `PCA_IDX_ALIGN:
                    center_align_bit_d = wbyte_q[3:0];
                `PCA_IDX_CTL: concat_d =
                    wbyte_q[`PCA_CONCAT_PAIR_UPPER_BIT:`PCA_CONCAT_PAIR_LOWER_BIT];
                `PCA_IDX_SCALE_A: scale_value_a_d = wbyte_q;
                `PCA_IDX_SCALE_B: scale_value_b_d = wbyte_q;
                default: begin
                    // Counter writes are accepted and ignored
                    if (widx >= `PCA_IDX_DTY0) begin
                        duty_d[widx[1:0]] = wbyte_q;
                    end else if (widx >= `PCA_IDX_PER0) begin
                        period_d[2'(widx - `PCA_IDX_PER0)] = wbyte_q;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            channel_enable_bit_q <= '0;
            start_polarity_bit_q <= '0;
            clock_select_q <= '0;
            center_align_bit_q <= '0;
            concat_q <= '0;
            prescale_field_a_q <= '0;
            prescale_field_b_q <= '0;
            scale_value_a_q <= `PCA_RESET_BYTE;
            scale_value_b_q <= `PCA_RESET_BYTE;
            for (int i = 0; i < 4; i++) begin
                period_q[i] <= `PCA_RESET_BYTE;
                duty_q[i] <= `PCA_RESET_BYTE;
            end
        end else begin
            channel_enable_bit_q <= channel_enable_bit_d;
            start_polarity_bit_q <= start_polarity_bit_d;
            clock_select_q <= clock_select_d;
            center_align_bit_q <= center_align_bit_d;
            concat_q <= concat_d;
            prescale_field_a_q <= prescale_field_a_d;
            prescale_field_b_q <= prescale_field_b_d;
            scale_value_a_q <= scale_value_a_d;
            scale_value_b_q <= scale_value_b_d;
            period_q <= period_d;
            duty_q <= duty_d;
        end
    end

    // Strobes instead of divided clocks keep one clock domain
    assign mask_a = 7'(`PCA_PRE_ALL_ONES >> (3'h7 - prescale_field_a_q));
    assign mask_b = 7'(`PCA_PRE_ALL_ONES >> (3'h7 - prescale_field_b_q));
    assign tick_a = (pre_cnt_q & mask_a) == mask_a;
    assign tick_b = (pre_cnt_q & mask_b) == mask_b;
    assign load_a = {(scale_value_a_q == '0) ? `PCA_SCALE_FULL
                     : {1'b0, scale_value_a_q}, 1'b0} - 10'h001;
    assign load_b = {(scale_value_b_q == '0) ? `PCA_SCALE_FULL
                     : {1'b0, scale_value_b_q}, 1'b0} - 10'h001;
    assign tick_sa = tick_a && scnt_a_q == '0;
    assign tick_sb = tick_b && scnt_b_q == '0;

    always_comb begin
        // Prescaler rests while every channel is off, saving power
        pre_cnt_d = (channel_enable_bit_q != '0) ? pre_cnt_q + 7'h01
                                                 : pre_cnt_q;
        scnt_a_d = scnt_a_q;
        scnt_b_d = scnt_b_q;
        if (tick_a) begin
            scnt_a_d = tick_sa ? load_a[8:0] : scnt_a_q - 9'h001;
        end
        if (tick_b) begin
            scnt_b_d = tick_sb ? load_b[8:0] : scnt_b_q - 9'h001;
        end
        // A scale write restarts its divider with the new value
        if (wr_fire && wlane_q && widx == `PCA_IDX_SCALE_A) begin
            scnt_a_d = {1'b0, wbyte_q} == '0 ? 9'h1ff
                : 9'({wbyte_q, 1'b0} - 9'h001);
        end
        if (wr_fire && wlane_q && widx == `PCA_IDX_SCALE_B) begin
            scnt_b_d = {1'b0, wbyte_q} == '0 ? 9'h1ff
                : 9'({wbyte_q, 1'b0} - 9'h001);
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            pre_cnt_q <= '0;
            scnt_a_q <= '0;
            scnt_b_q <= '0;
        end else begin
            pre_cnt_q <= pre_cnt_d;
            scnt_a_q <= scnt_a_d;
            scnt_b_q <= scnt_b_d;
        end
    end

    // Per-channel clock source and concatenation routing
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            if (n < 2) begin
                chan_tick[n] = clock_select_q[n] ? tick_sa
                                                 : tick_a;
            end else begin
                chan_tick[n] = clock_select_q[n] ? tick_sb
                                                 : tick_b;
            end
            chan_en[n] = channel_enable_bit_q[n];
            chan_per[n] = {8'h00, period_q[n]};
            chan_dty[n] = {8'h00, duty_q[n]};
            if (concat_q[n / 2]) begin
                if (n % 2 == 0) begin
                    chan_en[n] = 1'b0;
                end else begin
                    chan_per[n] = {period_q[n - 1], period_q[n]};
                    chan_dty[n] = {duty_q[n - 1], duty_q[n]};
                end
            end
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_chan
        pca_chan u_chan (
            .clock(clock),
            .srst(srst),
            .tick(chan_tick[g]),
            .channel_enable_bit(chan_en[g]),
            .start_polarity_bit(start_polarity_bit_q[g]),
            .center_align_bit(center_align_bit_q[g]),
            .period(chan_per[g]),
            .duty(chan_dty[g]),
            .count_q(chan_cnt[g]),
            .out_q(pwm_out[g])
        );
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready = wready_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

endmodule

// file: common/pca_defs.svh
`ifndef PCA_DEFS_SVH
`define PCA_DEFS_SVH

// Register indices; byte address is four times the index
`define PCA_IDX_ENABLE 5'h00
`define PCA_IDX_POLARITY 5'h01
`define PCA_IDX_CLKSEL 5'h02
`define PCA_IDX_PRESCALE 5'h03
`define PCA_IDX_ALIGN 5'h04
`define PCA_IDX_CTL 5'h05
`define PCA_IDX_SCALE_A 5'h08
`define PCA_IDX_SCALE_B 5'h09
`define PCA_IDX_CNT0 5'h0c
`define PCA_IDX_CNT3 5'h0f
`define PCA_IDX_PER0 5'h12
`define PCA_IDX_PER3 5'h15
`define PCA_IDX_DTY0 5'h18
`define PCA_IDX_DTY3 5'h1b

// Field positions
`define PCA_PRE_A_LSB 0
`define PCA_PRE_B_LSB 4
`define PCA_CONCAT_PAIR_LOWER_BIT 4
`define PCA_CONCAT_PAIR_UPPER_BIT 5

// Reset values and encodings
`define PCA_RESET_BYTE 8'h00
`define PCA_RESP_OKAY 2'h0
`define PCA_RESP_SLVERR 2'h2
`define PCA_SCALE_FULL 9'h100
`define PCA_PRE_ALL_ONES 8'h7f

`endif

// file: common/pca_pkg.sv
package pca_pkg;

typedef logic [7:0] pca_byte_t;
typedef logic [15:0] pca_word_t;
typedef logic [2:0] pca_pre_t;
typedef logic [8:0] pca_scnt_t;

endpackage

// file: verilog/pca_chan.sv
`timescale 1ns/1ps

module pca_chan (
    input wire logic clock,
    input wire logic srst,
    input wire logic tick,
    input wire logic channel_enable_bit,
    input wire logic start_polarity_bit,
    input wire logic center_align_bit,
    input wire pca_pkg::pca_word_t period,
    input wire pca_pkg::pca_word_t duty,
    output pca_pkg::pca_word_t count_q,
    output logic out_q
);

    logic running_q;
    logic running_d;
    logic down_q;
    logic down_d;
    logic out_d;
    pca_pkg::pca_word_t count_d;

    always_comb begin
        running_d = running_q;
        count_d = count_q;
        down_d = down_q;
        if (!channel_enable_bit) begin
            running_d = 1'b0;
            count_d = '0;
            down_d = 1'b0;
        end else if (tick) begin
            // Waveform waits for the first edge of its clock source
            running_d = 1'b1;
            if (running_q && period != '0) begin
                if (center_align_bit) begin
                    if (!down_q) begin
                        if (count_q >= period) begin
                            down_d = 1'b1;
                            count_d = count_q - 16'h0001;
                        end else begin
                            count_d = count_q + 16'h0001;
                        end
                    end else if (count_q == '0) begin
                        down_d = 1'b0;
                        count_d = 16'h0001;
                    end else begin
                        count_d = count_q - 16'h0001;
                    end
                end else begin
                    down_d = 1'b0;
                    if (count_q >= period - 16'h0001) begin
                        count_d = '0;
                    end else begin
                        count_d = count_q + 16'h0001;
                    end
                end
            end
        end
        // Polarity read live, so a change may clip one pulse
        if (!running_q) begin
            out_d = 1'b0;
        end else if (count_q < duty) begin
            out_d = start_polarity_bit;
        end else begin
            out_d = ~start_polarity_bit;
        end
    end

    always_ff @(posedge clock) begin
        if (srst) begin
            running_q <= 1'b0;
            count_q <= '0;
            down_q <= 1'b0;
            out_q <= 1'b0;
        end else begin
            running_q <= running_d;
            count_q <= count_d;
            down_q <= down_d;
            out_q <= out_d;
        end
    end

endmodule

// file: tb/pca_assertions.sv
`timescale 1ns/1ps

module pca_assertions (
    input wire logic clock,
    input wire logic srst,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [3:0] pwm_out
);
    default clocking @(posedge clock); endclocking
    default disable iff (srst);
    logic both_q;
    assign both_q = s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready;
    chk_bresp_hold:
        assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
            && $stable(s_axi_bresp)) else $error("write answer dropped");
    chk_rdata_hold:
        assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
            && $stable(s_axi_rdata)) else $error("read answer dropped");
    chk_rdata_width:
        assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
            else $error("read data above byte");
    chk_write_answer:
        assert property (both_q |-> ##2 s_axi_bvalid)
            else $error("write not answered");
    chk_read_answer:
        assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
            else $error("read not answered");
    chk_unmapped_write:
        assert property (both_q && s_axi_awaddr == 8'h18 |-> ##2
            s_axi_bresp == 2'h2) else $error("unmapped write accepted");
    chk_aw_blocked:
        assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
            else $error("write taken while answering");
    chk_reset_quiet:
        assert property ($fell(srst) |-> pwm_out == 4'h0 && !s_axi_bvalid)
            else $error("outputs active after reset");
    cover property (both_q && s_axi_awaddr == 8'h18);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property ($rose(pwm_out[3]));
endmodule

bind pca_top pca_assertions u_chk (.clock, .srst, .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .pwm_out);

// file: tb/pca_pin_monitor.sv
`timescale 1ns/1ps

// Pin load: measures last full period and high time per output
module pca_pin_monitor (
    input wire logic clock,
    input wire logic [3:0] pins,
    output int per_len [4],
    output int hi_len [4]
);
    int since [4] = '{0, 0, 0, 0};
    logic [3:0] last = 4'h0;
    always @(posedge clock) begin
        for (int i = 0; i < 4; i++) begin
            since[i] = since[i] + 1;
            if (pins[i] && !last[i]) begin
                per_len[i] = since[i];
                since[i] = 0;
            end
            if (!pins[i] && last[i]) hi_len[i] = since[i];
        end
        last = pins;
    end
endmodule

// file: tb/tb.sv
`timescale 1ns/1ps
`include "pca_defs.svh"

module tb;
    logic clock = 1'h0;
    logic srst = 1'h1;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0;
    logic s_axi_bready = 1'h0;
    logic s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [31:0] s_axi_rdata, rd;
    logic [3:0] pwm_out;
    int per_len [4];
    int hi_len [4];
    int n_errors = 0;
    int check_count = 0;
    always #10 clock = ~clock;
    pca_top u_dut (.clock, .srst, .s_axi_awaddr, .s_axi_awprot(3'h0),
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .pwm_out);
    pca_pin_monitor u_mon (.clock, .pins(pwm_out), .per_len, .hi_len);
    task automatic expect_eq(input logic [31:0] got, input logic [31:0] e);
        check_count++;
        if (got !== e) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task automatic wr(input logic [4:0] i, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_awaddr <= {1'h0, i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_bvalid !== 1'h1 && n < 100);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
        if (n >= 100) n_errors++;
    endtask
    task automatic rdr(input logic [4:0] i);
        int n;
        n = 0;
        @(posedge clock);
        s_axi_araddr <= {1'h0, i, 2'h0};
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do begin
            @(posedge clock);
            n++;
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end while (s_axi_rvalid !== 1'h1 && n < 100);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        if (n >= 100) n_errors++;
    endtask
    task automatic t_regs;
        logic [4:0] idx [4] = '{`PCA_IDX_POLARITY, `PCA_IDX_CLKSEL,
            `PCA_IDX_PRESCALE, `PCA_IDX_ALIGN};
        logic [7:0] val [4] = '{8'h0a, 8'h05, 8'h73, 8'h0f};
        for (int i = 0; i < 4; i++) begin
            rdr(idx[i]);
            expect_eq(rd, 32'h0);
            wr(idx[i], val[i]);
            rdr(idx[i]);
            expect_eq(rd, {24'h0, val[i]});
            expect_eq(rsp, `PCA_RESP_OKAY);
            wr(idx[i], 8'h00);
        end
        wr(5'h06, 8'h55);
        expect_eq(rsp, `PCA_RESP_SLVERR);
        rdr(5'h06);
        expect_eq(rd, 32'h0);
        $display("register test done");
    endtask
    task automatic t_pol;
        wr(`PCA_IDX_PRESCALE, 8'h02);
        wr(`PCA_IDX_PER0, 8'h04);
        wr(`PCA_IDX_DTY0, 8'h01);
        wr(`PCA_IDX_POLARITY, 8'h01);
        wr(`PCA_IDX_ENABLE, 8'h01);
        expect_eq(pwm_out[0], 1'h0);
        repeat (100) @(posedge clock);
        expect_eq(per_len[0], 16);
        expect_eq(hi_len[0], 4);
        wr(`PCA_IDX_POLARITY, 8'h00);
        repeat (100) @(posedge clock);
        expect_eq(hi_len[0], 12);
        wr(`PCA_IDX_PRESCALE, 8'h01);
        repeat (100) @(posedge clock);
        expect_eq(per_len[0], 8);
        expect_eq(hi_len[0], 6);
        wr(`PCA_IDX_ENABLE, 8'h00);
        repeat (4) @(posedge clock);
        expect_eq(pwm_out, 4'h0);
        $display("polarity test done");
    endtask
    task automatic t_clkb;
        wr(`PCA_IDX_PRESCALE, 8'h30);
        wr(`PCA_IDX_PER3 - 5'h1, 8'h04);
        wr(`PCA_IDX_DTY3 - 5'h1, 8'h01);
        wr(`PCA_IDX_POLARITY, 8'h04);
        wr(`PCA_IDX_ENABLE, 8'h04);
        repeat (150) @(posedge clock);
        expect_eq(per_len[2], 32);
        expect_eq(hi_len[2], 8);
        wr(`PCA_IDX_ENABLE, 8'h00);
        $display("clock b test done");
    endtask
    task automatic t_scaled;
        wr(`PCA_IDX_PRESCALE, 8'h00);
        wr(`PCA_IDX_SCALE_A, 8'h01);
        wr(`PCA_IDX_CLKSEL, 8'h02);
        wr(`PCA_IDX_PER0 + 5'h1, 8'h02);
        wr(`PCA_IDX_DTY0 + 5'h1, 8'h01);
        wr(`PCA_IDX_POLARITY, 8'h02);
        wr(`PCA_IDX_ENABLE, 8'h02);
        repeat (60) @(posedge clock);
        expect_eq(per_len[1], 4);
        expect_eq(hi_len[1], 2);
        wr(`PCA_IDX_SCALE_A, 8'h00);
        repeat (2600) @(posedge clock);
        expect_eq(per_len[1], 1024);
        wr(`PCA_IDX_CLKSEL, 8'h00);
        repeat (40) @(posedge clock);
        expect_eq(per_len[1], 2);
        expect_eq(hi_len[1], 1);
        wr(`PCA_IDX_ENABLE, 8'h00);
        $display("scaled clock test done");
    endtask
    task automatic t_center;
        wr(`PCA_IDX_ALIGN, 8'h08);
        wr(`PCA_IDX_PER3, 8'h04);
        wr(`PCA_IDX_DTY3, 8'h01);
        wr(`PCA_IDX_POLARITY, 8'h08);
        wr(`PCA_IDX_ENABLE, 8'h08);
        repeat (60) @(posedge clock);
        expect_eq(per_len[3], 8);
        wr(`PCA_IDX_ENABLE, 8'h00);
        wr(`PCA_IDX_ALIGN, 8'h00);
        $display("center test done");
    endtask
    task automatic t_concat;
        wr(`PCA_IDX_CTL, 8'h10);
        wr(`PCA_IDX_PER0, 8'h01);
        wr(`PCA_IDX_PER0 + 5'h1, 8'h00);
        wr(`PCA_IDX_DTY0, 8'h00);
        wr(`PCA_IDX_DTY0 + 5'h1, 8'h80);
        wr(`PCA_IDX_POLARITY, 8'h02);
        wr(`PCA_IDX_ENABLE, 8'h03);
        repeat (600) @(posedge clock);
        expect_eq(per_len[1], 256);
        expect_eq(hi_len[1], 128);
        expect_eq(pwm_out[0], 1'h0);
        wr(`PCA_IDX_ENABLE, 8'h00);
        wr(`PCA_IDX_CTL, 8'h00);
        $display("concat test done");
    endtask
    task automatic complete_run;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    initial begin
        #1000000;
        n_errors++;
        complete_run();
    end
    initial begin
        repeat (8) @(posedge clock);
        srst <= 1'h0;
        t_regs();
        t_pol();
        t_clkb();
        t_scaled();
        t_center();
        t_concat();
        complete_run();
    end
endmodule
